// ### hw/fpmc_top.sv
// front panel menu controller: pages, edits, timeout, lamps
`timescale 1ns/1ps
`default_nettype none
module fpmc_top #(
  parameter int unsigned TIMEOUT_CYC  = fpmc_pkg::TIMEOUT_CYC,
  parameter int unsigned PHASE_CYC    = fpmc_pkg::PHASE_CYC,
  parameter int unsigned DEBOUNCE_CYC = fpmc_pkg::DEBOUNCE_CYC
) (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_sys_rst,
  input  wire logic                   i_key,
  input  wire logic                   i_left,
  input  wire logic                   i_right,
  input  wire logic                   i_up,
  input  wire logic                   i_down,
  input  wire logic                   i_unlock,
  input  wire logic                   i_mute_sel,
  input  wire logic                   i_nv_valid,
  input  wire fpmc_pkg::fpmc_cfg_type i_nv_data,
  output logic                        o_nv_wr,
  output fpmc_pkg::fpmc_cfg_type      o_nv_data,
  output fpmc_pkg::fpmc_page_type     o_page,
  output logic [2:0]                  o_cursor,
  output logic                        o_save_yes,
  output fpmc_pkg::fpmc_cfg_type      o_edit,
  output logic [15:0]                 o_hw_freq,
  output logic [5:0]                  o_hw_gain,
  output logic                        o_hw_ext_ref,
  output logic                        o_alarm_lamp,
  output logic                        o_mute_lamp,
  output logic                        o_remote_lamp,
  output logic                        o_power_lamp
);
  typedef struct packed {
    fpmc_pkg::fpmc_page_type page;
    logic [2:0]              cursor;
    logic                    save_yes;
    fpmc_pkg::fpmc_cfg_type  edit;
    logic                    commit;
    logic [31:0]             idle;
    logic [31:0]             phase;
    logic [15:0]             hw_freq;
    logic [5:0]              hw_gain;
    logic                    hw_ext_ref;
    logic                    unl1;
    logic                    unl2;
    logic                    mute1;
    logic                    mute2;
    logic                    alarm;
    logic                    mute;
    logic                    remote;
  } fpmc_top_type;

  fpmc_top_type           st;
  fpmc_top_type           next_st;
  fpmc_pkg::fpmc_cfg_type saved;
  logic                   ev_key;
  logic                   ev_left;
  logic                   ev_right;
  logic                   ev_up;
  logic                   ev_down;
  logic                   any_ev;

  fpmc_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db_key (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_sw(i_key),
    .o_press(ev_key));
  fpmc_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db_left (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_sw(i_left),
    .o_press(ev_left));
  fpmc_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db_right (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_sw(i_right),
    .o_press(ev_right));
  fpmc_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db_up (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_sw(i_up),
    .o_press(ev_up));
  fpmc_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db_down (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_sw(i_down),
    .o_press(ev_down));

  fpmc_store u_store (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_nv_valid(i_nv_valid),
    .i_nv_data (i_nv_data),
    .i_wr      (st.commit),
    .i_wdata   (st.edit),
    .o_data    (saved),
    .o_nv_wr   (o_nv_wr),
    .o_nv_data (o_nv_data)
  );

  assign any_ev = ev_key | ev_left | ev_right | ev_up | ev_down;

  // last cursor position of each page; the return marker sits one past it
  function automatic logic [2:0] last_cur(fpmc_pkg::fpmc_page_type pg);
    case (pg)
      fpmc_pkg::PG_FREQ: last_cur = 3'(fpmc_pkg::FREQ_DIGITS - 1);
      fpmc_pkg::PG_GAIN: last_cur = 3'h1;
      fpmc_pkg::PG_ADDR: last_cur = 3'h1;
      default:           last_cur = 3'h0;
    endcase
  endfunction : last_cur

  // one bcd digit step with wrap, used up and down
  function automatic logic [3:0] bcd_step(logic [3:0] d, logic up);
    if (up)
      bcd_step = (d >= 4'h9) ? 4'h0 : d + 4'h1;
    else
      bcd_step = (d == 4'h0) ? 4'h9 : d - 4'h1;
  endfunction : bcd_step

  // gain step held inside the legal range
  function automatic logic [5:0] gain_step(logic [5:0] g, logic [5:0] s,
                                           logic up);
    logic [6:0] t;
    t = up ? {1'b0, g} + {1'b0, s} : {1'b0, g} - {1'b0, s};
    if (!up && (g < s + fpmc_pkg::GAIN_MIN))
      gain_step = fpmc_pkg::GAIN_MIN;
    else if (t > {1'b0, fpmc_pkg::GAIN_MAX})
      gain_step = fpmc_pkg::GAIN_MAX;
    else
      gain_step = t[5:0];
  endfunction : gain_step

  always_comb
  begin
    logic [2:0] lc;
    logic       vert;
    logic [3:0] dig;
    lc           = last_cur(st.page);
    vert         = ev_up | ev_down;
    dig          = 4'h0;
    next_st      = st;
    next_st.commit = 1'b0;
    next_st.unl1  = i_unlock;
    next_st.unl2  = st.unl1;
    next_st.mute1 = i_mute_sel;
    next_st.mute2 = st.mute1;
    next_st.alarm = st.unl2;
    next_st.mute  = st.mute2;
    next_st.remote = saved.rmode;
    next_st.hw_freq    = saved.freq;
    next_st.hw_ext_ref = saved.ext_ref;
    next_st.hw_gain    = saved.gain;
    if (st.page >= fpmc_pkg::PG_FREQ)
      next_st.hw_gain = st.edit.gain;
    if (any_ev)
      next_st.idle = 32'h0;
    else if (st.idle < TIMEOUT_CYC)
      next_st.idle = st.idle + 32'h1;
    case (st.page)
      fpmc_pkg::PG_LAMP, fpmc_pkg::PG_VER, fpmc_pkg::PG_STAT:
      begin
        if (st.phase >= PHASE_CYC - 1)
        begin
          next_st.phase = 32'h0;
          next_st.page  = fpmc_pkg::fpmc_page_type'(st.page + 4'h1);
        end
        else
          next_st.phase = st.phase + 32'h1;
      end
      fpmc_pkg::PG_NORMAL:
      begin
        next_st.edit = saved;
        if (ev_key)
        begin
          next_st.page   = fpmc_pkg::PG_FREQ;
          next_st.cursor = 3'h0;
        end
      end
      default:
      begin
        if (st.idle >= TIMEOUT_CYC - 1 && !any_ev)
        begin
          next_st.page = fpmc_pkg::PG_NORMAL;
          next_st.edit = saved;
        end
        else if (st.page == fpmc_pkg::PG_SAVE)
        begin
          if (ev_left | ev_right | vert)
            next_st.save_yes = !st.save_yes;
          if (ev_key)
          begin
            next_st.page = fpmc_pkg::PG_NORMAL;
            if (st.save_yes)
              next_st.commit = 1'b1;
            else
              next_st.edit = saved;
          end
        end
        else if (ev_key)
        begin
          next_st.cursor = 3'h0;
          if (st.cursor == fpmc_pkg::CUR_RET ||
              st.page == fpmc_pkg::PG_ADDR)
          begin
            next_st.page     = fpmc_pkg::PG_SAVE;
            next_st.save_yes = 1'b0;
          end
          else
            next_st.page = fpmc_pkg::fpmc_page_type'(st.page + 4'h1);
        end
        else if (ev_left)
        begin
          if (st.cursor == fpmc_pkg::CUR_RET)
            next_st.cursor = lc;
          else if (st.cursor != 3'h0)
            next_st.cursor = st.cursor - 3'h1;
        end
        else if (ev_right)
        begin
          if (st.cursor == lc)
            next_st.cursor = fpmc_pkg::CUR_RET;
          else if (st.cursor != fpmc_pkg::CUR_RET)
            next_st.cursor = st.cursor + 3'h1;
        end
        else if (vert && st.cursor != fpmc_pkg::CUR_RET)
        begin
          case (st.page)
            fpmc_pkg::PG_FREQ:
            begin
              // cursor 0 is the most significant digit
              case (st.cursor)
                3'h0: dig = st.edit.freq[15:12];
                3'h1: dig = st.edit.freq[11:8];
                3'h2: dig = st.edit.freq[7:4];
                default: dig = st.edit.freq[3:0];
              endcase
              dig = bcd_step(dig, ev_up);
              case (st.cursor)
                3'h0: next_st.edit.freq[15:12] = dig;
                3'h1: next_st.edit.freq[11:8]  = dig;
                3'h2: next_st.edit.freq[7:4]   = dig;
                default: next_st.edit.freq[3:0] = dig;
              endcase
            end
            fpmc_pkg::PG_GAIN:
              next_st.edit.gain = gain_step(st.edit.gain,
                (st.cursor == 3'h0) ? 6'h0a : 6'h01, ev_up);
            fpmc_pkg::PG_REMOTE:
              next_st.edit.remote = !st.edit.remote;
            fpmc_pkg::PG_REF:
              next_st.edit.ext_ref = !st.edit.ext_ref;
            fpmc_pkg::PG_RMODE:
              next_st.edit.rmode = !st.edit.rmode;
            fpmc_pkg::PG_ADDR:
            begin
              if (ev_up)
                next_st.edit.addr = (st.edit.addr == fpmc_pkg::ADDR_MAX) ?
                  5'h0 : st.edit.addr + 5'h1;
              else
                next_st.edit.addr = (st.edit.addr == 5'h0) ?
                  fpmc_pkg::ADDR_MAX : st.edit.addr - 5'h1;
            end
            default: ;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st      <= '0;
      st.page <= fpmc_pkg::PG_LAMP;
    end
    else
      st <= next_st;
  end

  assign o_page        = st.page;
  assign o_cursor      = st.cursor;
  assign o_save_yes    = st.save_yes;
  assign o_edit        = st.edit;
  assign o_hw_freq     = st.hw_freq;
  assign o_hw_gain     = st.hw_gain;
  assign o_hw_ext_ref  = st.hw_ext_ref;
  assign o_alarm_lamp  = st.alarm;
  assign o_mute_lamp   = st.mute;
  assign o_remote_lamp = st.remote;
  assign o_power_lamp  = 1'b1;
endmodule : fpmc_top
`default_nettype wire

// ### hw/fpmc_pkg.sv
// constants and types for the front panel menu controller
package fpmc_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned TIMEOUT_S     = 30;
  localparam int unsigned TIMEOUT_CYC   = CLK_HZ * TIMEOUT_S;
  localparam int unsigned DEBOUNCE_MS   = 10;
  localparam int unsigned DEBOUNCE_CYC  = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned PHASE_MS      = 1000;
  localparam int unsigned PHASE_CYC     = CLK_HZ / 1000 * PHASE_MS;
  localparam int unsigned FREQ_DIGITS   = 4;
  localparam logic [5:0]  GAIN_MIN      = 6'h1e;
  localparam logic [5:0]  GAIN_MAX      = 6'h32;
  localparam logic [5:0]  GAIN_RST      = 6'h1e;
  localparam logic [15:0] FREQ_RST      = 16'h0720;
  localparam logic [4:0]  ADDR_MAX      = 5'h1f;
  localparam logic [2:0]  CUR_RET       = 3'h7;

  typedef enum logic [3:0] {
    PG_LAMP, PG_VER, PG_STAT, PG_NORMAL, PG_FREQ, PG_GAIN, PG_REMOTE,
    PG_REF, PG_RMODE, PG_ADDR, PG_SAVE
  } fpmc_page_type;

  typedef struct packed {
    logic [15:0] freq;
    logic [5:0]  gain;
    logic        remote;
    logic        ext_ref;
    logic        rmode;
    logic [4:0]  addr;
  } fpmc_cfg_type;
endpackage : fpmc_pkg

// ### hw/fpmc_debounce.sv
// synchroniser and debouncer for one switch, one pulse per press
`timescale 1ns/1ps
`default_nettype none
module fpmc_debounce #(
  parameter int unsigned STABLE_CYC = fpmc_pkg::DEBOUNCE_CYC
) (
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_sw,
  output logic      o_press
);
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        level;
    logic        press;
    logic [31:0] cnt;
  } fpmc_db_type;

  fpmc_db_type st;
  fpmc_db_type next_st;

  always_comb
  begin
    next_st       = st;
    next_st.s1    = i_sw;
    next_st.s2    = st.s1;
    next_st.press = 1'b0;
    if (st.s2 == st.level)
      next_st.cnt = 32'h0;
    else if (st.cnt >= STABLE_CYC - 1)
    begin
      next_st.cnt   = 32'h0;
      next_st.level = st.s2;
      next_st.press = st.s2;
    end
    else
      next_st.cnt = st.cnt + 32'h1;
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_press = st.press;
endmodule : fpmc_debounce
`default_nettype wire

// ### hw/fpmc_store.sv
// retained settings store, written only on commit
`timescale 1ns/1ps
`default_nettype none
module fpmc_store (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic                  i_nv_valid,
  input  wire fpmc_pkg::fpmc_cfg_type i_nv_data,
  input  wire logic                  i_wr,
  input  wire fpmc_pkg::fpmc_cfg_type i_wdata,
  output fpmc_pkg::fpmc_cfg_type     o_data,
  output logic                       o_nv_wr,
  output fpmc_pkg::fpmc_cfg_type     o_nv_data
);
  // the image lives in an external nonvolatile part; it is reloaded once
  // after reset when that part reports valid contents
  typedef struct packed {
    fpmc_pkg::fpmc_cfg_type cfg;
    logic                   loaded;
    logic                   wr;
  } fpmc_st_type;

  fpmc_st_type st;
  fpmc_st_type next_st;

  always_comb
  begin
    next_st    = st;
    next_st.wr = 1'b0;
    if (!st.loaded && i_nv_valid)
    begin
      next_st.cfg    = i_nv_data;
      next_st.loaded = 1'b1;
    end
    else if (i_wr)
    begin
      next_st.cfg = i_wdata;
      next_st.wr  = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st          <= '0;
      st.cfg.freq <= fpmc_pkg::FREQ_RST;
      st.cfg.gain <= fpmc_pkg::GAIN_RST;
    end
    else
      st <= next_st;
  end

  assign o_data    = st.cfg;
  assign o_nv_wr   = st.wr;
  assign o_nv_data = st.cfg;
endmodule : fpmc_store
`default_nettype wire

// ### testbench/fpmc_chk.sv
// port checker for the front panel menu controller
`timescale 1ns/1ps
`default_nettype none
module fpmc_chk #(
  parameter int unsigned TIMEOUT_CYC = 200
) (
  input wire logic                   i_ref_clk,
  input wire logic                   i_sys_rst,
  input wire logic                   i_key,
  input wire logic                   i_left,
  input wire logic                   i_right,
  input wire logic                   i_up,
  input wire logic                   i_down,
  input wire logic                   i_unlock,
  input wire logic                   i_mute_sel,
  input wire logic                   o_nv_wr,
  input wire fpmc_pkg::fpmc_page_type o_page,
  input wire logic [2:0]             o_cursor,
  input wire logic                   o_save_yes,
  input wire fpmc_pkg::fpmc_cfg_type o_edit,
  input wire logic [15:0]            o_hw_freq,
  input wire logic [5:0]             o_hw_gain,
  input wire logic                   o_alarm_lamp,
  input wire logic                   o_mute_lamp,
  input wire logic                   o_power_lamp
);
  logic [31:0] idle;
  wire logic   sw;
  // raw pins restart the count; debounce slack is allowed for below
  assign sw = i_key | i_left | i_right | i_up | i_down;
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      idle <= 32'h0;
    else if (sw || o_page < fpmc_pkg::PG_FREQ)
      idle <= 32'h0;
    else
      idle <= idle + 32'h1;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_leave_yes;
    (o_page == fpmc_pkg::PG_SAVE && o_save_yes) ##1
    (o_page != fpmc_pkg::PG_SAVE);
  endsequence
  sequence s_edit_steady;
    o_page >= fpmc_pkg::PG_FREQ && $past(o_page) >= fpmc_pkg::PG_FREQ
    && $stable(o_edit.gain);
  endsequence
  AST_TIMEOUT: assert property (idle <= TIMEOUT_CYC + 8)
    else $error("edit page held past the inactivity limit");
  AST_COMMIT: assert property (s_leave_yes |-> ##[0:2] o_nv_wr)
    else $error("save yes left without a store write");
  AST_NO_STRAY_WR: assert property (
    o_nv_wr |-> $past(o_page, 2) == fpmc_pkg::PG_SAVE)
    else $error("store written outside the save page");
  AST_WR_PULSE: assert property (o_nv_wr |=> !o_nv_wr)
    else $error("store write longer than one cycle");
  AST_FREQ_HOLD: assert property (
    (o_page >= fpmc_pkg::PG_FREQ && o_page != fpmc_pkg::PG_SAVE)
    |=> $stable(o_hw_freq))
    else $error("frequency applied before save");
  AST_GAIN_LIVE: assert property (s_edit_steady |-> o_hw_gain == o_edit.gain)
    else $error("edited gain not applied live");
  AST_GAIN_RANGE: assert property (
    o_page >= fpmc_pkg::PG_FREQ |->
    (o_edit.gain >= 6'h1e && o_edit.gain <= 6'h32))
    else $error("gain outside range");
  AST_CURSOR: assert property (o_cursor <= 3'h3 || o_cursor == 3'h7)
    else $error("cursor at an unused position");
  AST_ALARM_ON: assert property (i_unlock [*4] |=> o_alarm_lamp)
    else $error("alarm lamp dark during unlock");
  AST_ALARM_OFF: assert property (!i_unlock [*4] |=> !o_alarm_lamp)
    else $error("alarm lamp lit while locked");
  AST_MUTE: assert property (i_mute_sel [*4] |=> o_mute_lamp)
    else $error("mute lamp dark while muted");
  AST_POWER: assert property (o_power_lamp)
    else $error("power lamp dark");
endmodule : fpmc_chk
bind fpmc_top fpmc_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) fpmc_chk_inst (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_key(i_key),
  .i_left(i_left), .i_right(i_right), .i_up(i_up), .i_down(i_down),
  .i_unlock(i_unlock), .i_mute_sel(i_mute_sel), .o_nv_wr(o_nv_wr),
  .o_page(o_page), .o_cursor(o_cursor), .o_save_yes(o_save_yes),
  .o_edit(o_edit), .o_hw_freq(o_hw_freq), .o_hw_gain(o_hw_gain),
  .o_alarm_lamp(o_alarm_lamp), .o_mute_lamp(o_mute_lamp),
  .o_power_lamp(o_power_lamp));
`default_nettype wire

// ### testbench/fpmc_operator.sv
// operator model: presses one front panel switch at a time
`timescale 1ns/1ps
`default_nettype none
module fpmc_operator (
  input  wire logic       i_ref_clk,
  input  wire logic       i_go,
  input  wire logic [2:0] i_sel,
  output logic            o_key,
  output logic            o_left,
  output logic            o_right,
  output logic            o_up,
  output logic            o_down,
  output logic            o_busy
);
  logic [4:0] cnt = 5'h00;
  logic [2:0] sel = 3'h0;
  logic       hold;
  always @(negedge i_ref_clk)
  begin
    if (cnt == 5'h00 && i_go)
    begin
      cnt <= 5'h10;
      sel <= i_sel;
    end
    else if (cnt != 5'h00)
      cnt <= cnt - 5'h01;
  end
  // held 8 cycles, released 8: long enough to debounce once
  assign hold    = cnt > 5'h08;
  assign o_key   = hold && sel == 3'h0;
  assign o_left  = hold && sel == 3'h1;
  assign o_right = hold && sel == 3'h2;
  assign o_up    = hold && sel == 3'h3;
  assign o_down  = hold && sel == 3'h4;
  assign o_busy  = cnt != 5'h00;
endmodule : fpmc_operator
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the front panel menu controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [2:0] K = 3'h0, L = 3'h1, R = 3'h2, U = 3'h3, D = 3'h4;
  logic                   i_ref_clk = 1'b0;
  logic                   i_sys_rst = 1'b1;
  logic                   i_unlock = 1'b0;
  logic                   i_mute_sel = 1'b0;
  logic                   go = 1'b0;
  logic [2:0]             sel = 3'h0;
  logic                   key, left, right, up, down, busy;
  fpmc_pkg::fpmc_cfg_type nv_img = '{16'h1234, 6'h28, 1'b0, 1'b0, 1'b0,
                                     5'h00};
  fpmc_pkg::fpmc_cfg_type o_nv_data, o_edit;
  fpmc_pkg::fpmc_page_type o_page;
  logic [2:0]             o_cursor;
  logic [15:0]            o_hw_freq, f;
  logic [5:0]             o_hw_gain;
  logic                   o_save_yes, o_alarm_lamp, o_mute_lamp;
  logic                   o_remote_lamp, o_power_lamp, o_hw_ext_ref;
  int                     mismatches = 0;
  int                     cmp_count = 0;
  initial forever #12.5 i_ref_clk = ~i_ref_clk;
  fpmc_operator fpmc_operator_inst (.i_ref_clk(i_ref_clk), .i_go(go),
    .i_sel(sel), .o_key(key), .o_left(left), .o_right(right), .o_up(up),
    .o_down(down), .o_busy(busy));
  // short counts keep the run brief; expectations use these values
  fpmc_top #(.TIMEOUT_CYC(200), .PHASE_CYC(10), .DEBOUNCE_CYC(3))
  fpmc_top_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_key(key), .i_left(left), .i_right(right), .i_up(up),
    .i_down(down), .i_unlock(i_unlock), .i_mute_sel(i_mute_sel),
    .i_nv_valid(1'b1), .i_nv_data(nv_img), .o_nv_wr(),
    .o_nv_data(o_nv_data), .o_page(o_page), .o_cursor(o_cursor),
    .o_save_yes(o_save_yes), .o_edit(o_edit), .o_hw_freq(o_hw_freq),
    .o_hw_gain(o_hw_gain), .o_hw_ext_ref(o_hw_ext_ref),
    .o_alarm_lamp(o_alarm_lamp),
    .o_mute_lamp(o_mute_lamp), .o_remote_lamp(o_remote_lamp),
    .o_power_lamp(o_power_lamp));
  task tally_and_finish;
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task press(input logic [2:0] s);
    int n;
    sel <= s;
    go <= 1'b1;
    @(negedge i_ref_clk);
    go <= 1'b0;
    repeat (2) @(negedge i_ref_clk);
    n = 0;
    while (busy === 1'b1 && n < 40)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n == 40)
    begin
      mismatches++;
      tally_and_finish();
    end
    @(negedge i_ref_clk);
  endtask : press
  task t_powerup;
    logic [3:0] last;
    int         n;
    repeat (10) @(negedge i_ref_clk);
    chk(o_page, fpmc_pkg::PG_LAMP);
    i_sys_rst <= 1'b0;
    last = 4'h0;
    for (n = 0; n < 80 && last != 4'(fpmc_pkg::PG_NORMAL); n++)
    begin
      @(negedge i_ref_clk);
      if (o_page !== last)
      begin
        chk(o_page, last + 4'h1);
        last = o_page;
      end
    end
    chk(last, fpmc_pkg::PG_NORMAL);
    chk(o_hw_freq, 16'h1234);
    chk(o_hw_gain, 6'h28);
  endtask : t_powerup
  task t_commit;
    press(K);
    chk(o_page, fpmc_pkg::PG_FREQ);
    press(U);
    f = o_edit.freq;
    chk(f == 16'h2234 || f == 16'h1235, 1'b1);
    press(K);
    chk(o_page, fpmc_pkg::PG_GAIN);
    press(U);
    chk(o_hw_gain, 6'h32);
    press(U);
    chk(o_edit.gain, 6'h32);
    press(R);
    chk(o_cursor, 3'h1);
    press(D);
    chk(o_edit.gain, 6'h31);
    press(K);
    chk(o_page, fpmc_pkg::PG_REMOTE);
    press(U);
    chk(o_edit.remote, 1'b1);
    press(D);
    chk(o_edit.remote, 1'b0);
    press(K);
    chk(o_page, fpmc_pkg::PG_REF);
    press(U);
    chk(o_edit.ext_ref, 1'b1);
    press(K);
    press(U);
    chk(o_edit.rmode, 1'b1);
    press(K);
    chk(o_page, fpmc_pkg::PG_ADDR);
    press(U);
    chk(o_edit.addr, 5'h01);
    chk(o_hw_freq, 16'h1234);
    chk(o_hw_ext_ref, 1'b0);
    press(K);
    chk(o_page, fpmc_pkg::PG_SAVE);
    press(U);
    chk(o_save_yes, 1'b1);
    press(K);
    chk(o_nv_data, {f, 6'h31, 3'h3, 5'h01});
    chk(o_hw_freq, f);
    chk(o_hw_ext_ref, 1'b1);
    chk(o_remote_lamp, 1'b1);
  endtask : t_commit
  task t_discard;
    press(K);
    press(U);
    repeat (4) press(R);
    chk(o_cursor, 3'h7);
    press(K);
    chk(o_page, fpmc_pkg::PG_SAVE);
    press(K);
    chk(o_edit.freq, f);
    chk(o_hw_freq, f);
    chk(o_nv_data.freq, f);
  endtask : t_discard
  task t_timeout;
    int n;
    press(K);
    press(K);
    press(U);
    chk(o_hw_gain, 6'h32);
    for (n = 0; n < 260 && o_page === fpmc_pkg::PG_GAIN; n++)
      @(negedge i_ref_clk);
    chk(o_page, fpmc_pkg::PG_NORMAL);
    chk(n > 150, 1'b1);
    // applied gain lags the page change by one register stage
    @(negedge i_ref_clk);
    chk(o_hw_gain, 6'h31);
  endtask : t_timeout
  task t_lamps;
    i_unlock <= 1'b1;
    repeat (5) @(negedge i_ref_clk);
    chk(o_alarm_lamp, 1'b1);
    i_unlock <= 1'b0;
    i_mute_sel <= 1'b1;
    repeat (5) @(negedge i_ref_clk);
    chk(o_alarm_lamp, 1'b0);
    chk(o_mute_lamp, 1'b1);
    chk(o_power_lamp, 1'b1);
  endtask : t_lamps
  initial
  begin
    t_powerup();
    t_commit();
    t_discard();
    t_timeout();
    t_lamps();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
